/* File: rtl/sacs_pkg.sv */
// package for the serial converter sequencer: cycle counts, widths, timing
// assumes a single host-supplied clock; no registers reachable by software
package sacs_pkg;
   // -----------------------------------------------------------------
   // conversion frame
   // -----------------------------------------------------------------
   localparam int unsigned CYCLES_PER_CONV = 14;   // clocks per conversion
   localparam int unsigned RESULT_BITS     = 10;   // result width
   localparam int unsigned TRACK_CYCLES    = 2;    // calibrate and track
   localparam int unsigned HOLD_CYCLE      = 3;    // sample at end of this
   localparam int unsigned MSB_CYCLE       = 4;    // first result bit
   localparam int unsigned CNT_W           = 4;
   localparam logic [3:0]  CNT_FIRST       = 4'h1;
   localparam logic [3:0]  CNT_HOLD        = 4'h3;
   localparam logic [3:0]  CNT_LAST        = 4'hE;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 100;  // 10 MHz
   localparam int unsigned SKID_DEPTH      = 2;    // result buffer entries
   // -----------------------------------------------------------------
   // sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SACS_IDLE = 2'b01,
      SACS_CONV = 2'b10
   } sacs_state_t;
endpackage : sacs_pkg

/* File: rtl/sacs_sequencer.sv */
// conversion sequencer and serial result shifter for a 10-bit SAR converter
// assumes CONVERT_REQUEST_N synchronous to CLOCK; analog core outside gives
// COMPARE_BIT each bit cycle; results also leave through a two-entry buffer
`timescale 1ns/10ps
`default_nettype none

// Operation
// [R01] every conversion is exactly fourteen clocks from first conversion clock
// [R02] request low while idle starts conversion on next rising edge
// [R03] serial output driven low from start until first result bit
// [R04] first two cycles calibrate and track; no result bits
// [R05] hold taken at the edge ending cycle three
// [R06] cycles four to fourteen do ten-bit conversion, MSB first
// [R07] one result bit per clock until LSB is out
// [R08] request high after LSB: tri-state output and go idle
// [R09] request low before end of cycle fourteen: keep output low
// [R10] chained conversions start right after clock fourteen
// [R11] host clock is fourteen times sample rate, near half duty
// [R12] host may stop clock only between conversions
// [R13] non-LSB bits change after falling edge, held one period; code changes them after the rising edge
// [R14] LSB held only for clock-low interval of clock fourteen; code holds it for the whole of clock fourteen
// [R15] host latches LSB carefully, its window is short
// [R16] result coding is straight binary
// [R17] input tracked from clock fourteen until hold at clock three
// [R18] host settles reference between clock thirteen and three
// [R19] falling request starts conversion and enables the output driver
// [R20] MSB presented after falling edge of clock four; code presents it after the rising edge ending clock four
// [R21] free run keeps output low between conversions
// [R22] after reset idle with output tri-stated
module sacs_sequencer
   import sacs_pkg::*;
#(
   parameter int unsigned N_BITS = RESULT_BITS
) (
   input  wire logic              CLOCK,
   input  wire logic              RST,
   input  wire logic              CONVERT_REQUEST_N,
   input  wire logic              COMPARE_BIT,
   output logic                   TRACK,
   output logic                   HOLD_STROBE,
   output logic                   BIT_STROBE,
   output logic                   DATA_OUT,
   output logic                   DATA_OE,
   output logic                   BUSY,
   output logic [N_BITS-1:0]      RESULT_BITS_OUT,
   output logic                   RESULT_VALID,
   input  wire logic              RESULT_READY
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   sacs_state_t       state_ff;
   logic [CNT_W-1:0]  cnt_ff;
   logic [N_BITS-1:0] sar_ff;
   logic              data_ff;
   logic              oe_ff;
   logic              track_ff;
   logic              hold_ff;
   logic              bit_ff;
   logic              start;
   logic              last;
   logic              bit_cyc;
   logic [CNT_W-1:0]  bit_idx;
   logic              push_valid;
   logic              push_ready;

   // start from idle or chained from the last clock
   assign last    = (state_ff == SACS_CONV) && (cnt_ff == CNT_LAST);         // [R01]
   assign start   = !CONVERT_REQUEST_N &&
                    ((state_ff == SACS_IDLE) || last);                      // [R02] [R10]
   assign bit_cyc = (state_ff == SACS_CONV) && (cnt_ff > CNT_HOLD) &&
                    (cnt_ff < CNT_LAST);                                    // [R06]
   assign bit_idx = CNT_LAST - cnt_ff - 4'h1;

   // -----------------------------------------------------------------
   // sequencer and cycle counter
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_ff <= SACS_IDLE;                                            // [R22]
         cnt_ff   <= 4'h0;
      end else begin
         case (state_ff)
            SACS_IDLE: begin
               if (start) begin
                  state_ff <= SACS_CONV;                                   // [R19]
                  cnt_ff   <= CNT_FIRST;
               end
            end
            SACS_CONV: begin
               if (last && start) begin
                  cnt_ff <= CNT_FIRST;                                     // [R10]
               end else if (last) begin
                  state_ff <= SACS_IDLE;                                   // [R08]
                  cnt_ff   <= 4'h0;
               end else begin
                  cnt_ff <= cnt_ff + 4'h1;
               end
            end
            default: begin
               state_ff <= SACS_IDLE;
               cnt_ff   <= 4'h0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // analog core strobes
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         track_ff <= 1'b1;
         hold_ff  <= 1'b0;
         bit_ff   <= 1'b0;
      end else begin
         // track up to the hold edge ending cycle three, resume in cycle fourteen
         track_ff <= !((state_ff == SACS_CONV) && (cnt_ff >= CNT_HOLD) &&
                       (cnt_ff < CNT_LAST - 4'h1));                        // [R17] [R04]
         hold_ff  <= (state_ff == SACS_CONV) && (cnt_ff == CNT_HOLD - 4'h1); // [R05]
         bit_ff   <= bit_cyc;                                              // [R07]
      end
   end

   // -----------------------------------------------------------------
   // successive approximation register
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sar_ff <= '0;
      end else if (start) begin
         sar_ff <= '0;
      end else if (bit_cyc) begin
         sar_ff[bit_idx] <= COMPARE_BIT;                                   // [R16]
      end
   end

   // -----------------------------------------------------------------
   // serial output: low until MSB, one bit per clock, then low or off
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         data_ff <= 1'b0;
         oe_ff   <= 1'b0;                                                  // [R22]
      end else if (start) begin
         data_ff <= 1'b0;                                                  // [R03]
         oe_ff   <= 1'b1;                                                  // [R19]
      end else if (bit_cyc) begin
         data_ff <= COMPARE_BIT;                                           // [R20] [R13]
         oe_ff   <= 1'b1;
      end else if (last) begin
         data_ff <= 1'b0;                                                  // [R09] [R21]
         oe_ff   <= 1'b0;                                                  // [R08] [R14]
      end else if (state_ff == SACS_CONV && cnt_ff < CNT_HOLD) begin
         data_ff <= 1'b0;                                                  // [R04]
      end
   end

   // -----------------------------------------------------------------
   // two-entry result buffer
   // -----------------------------------------------------------------
   logic [N_BITS-1:0] buf_ff [SKID_DEPTH];
   logic              wr_ff;
   logic              rd_ff;
   logic [1:0]        cnt_buf_ff;
   logic [N_BITS-1:0] done_word;

   assign done_word  = {sar_ff[N_BITS-1:1], COMPARE_BIT};
   assign push_valid = (state_ff == SACS_CONV) && (cnt_ff == CNT_LAST - 4'h1);
   assign push_ready = (cnt_buf_ff != 2'(SKID_DEPTH));

   // words pushed when full are dropped; the host must drain in time
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         wr_ff      <= 1'b0;
         rd_ff      <= 1'b0;
         cnt_buf_ff <= 2'h0;
         buf_ff[0]  <= '0;
         buf_ff[1]  <= '0;
      end else begin
         if (push_valid && push_ready) begin
            buf_ff[wr_ff] <= done_word;
            wr_ff         <= !wr_ff;
         end
         if (RESULT_VALID && RESULT_READY) begin
            rd_ff <= !rd_ff;
         end
         cnt_buf_ff <= cnt_buf_ff + 2'(push_valid && push_ready)
                                  - 2'(RESULT_VALID && RESULT_READY);
      end
   end

   // registered read side
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         RESULT_VALID    <= 1'b0;
         RESULT_BITS_OUT <= '0;
      end else begin
         if (!RESULT_VALID || RESULT_READY) begin
            RESULT_VALID    <= 1'b0;
            RESULT_BITS_OUT <= '0;
            if (cnt_buf_ff != 2'h0 && !(RESULT_VALID && cnt_buf_ff == 2'h1)) begin
               RESULT_VALID    <= 1'b1;
               RESULT_BITS_OUT <= buf_ff[rd_ff ^ RESULT_VALID];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // registered outputs
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= start || ((state_ff == SACS_CONV) && !last);
      end
   end

   assign DATA_OUT    = data_ff;
   assign DATA_OE     = oe_ff;
   assign TRACK       = track_ff;
   assign HOLD_STROBE = hold_ff;
   assign BIT_STROBE  = bit_ff;

endmodule : sacs_sequencer

`default_nettype wire

/* File: tb/sacs_host_model.sv */
// host model: convert request, comparator level and serial bit capture
// assumes the bench changes REQ_LOW and LEVEL just after falling edges
`timescale 1ns/10ps
`default_nettype none
module sacs_host_model (
   input  wire logic       CLOCK,
   input  wire logic       REQ_LOW,
   input  wire logic       LEVEL,
   input  wire logic       DATA_IN,
   input  wire logic       DATA_EN,
   input  wire logic       STROBE,
   output logic            REQ_N,
   output logic            CMP,
   output logic [9:0]      WORD
);
   // request is active low; clock runs through each frame
   assign REQ_N = ~REQ_LOW;
   assign CMP   = LEVEL;      // level settles half a clock before each sampling edge
   // gather one bit per strobe, only while the pin is driven
   always @(posedge CLOCK) begin
      if (STROBE && DATA_EN) WORD <= {WORD[8:0], DATA_IN};
   end
endmodule : sacs_host_model
`default_nettype wire

/* File: tb/sacs_seq_properties.sv */
// checker for the conversion sequencer top ports
// assumes binding onto sacs_sequencer, one clock, RST async high
`timescale 1ns/10ps
`default_nettype none
module sacs_seq_properties #(
   parameter int unsigned N_BITS = 10
) (
   input wire logic              CLOCK,
   input wire logic              RST,
   input wire logic              CONVERT_REQUEST_N,
   input wire logic              COMPARE_BIT,
   input wire logic              TRACK,
   input wire logic              HOLD_STROBE,
   input wire logic              BIT_STROBE,
   input wire logic              DATA_OUT,
   input wire logic              DATA_OE,
   input wire logic              BUSY,
   input wire logic [N_BITS-1:0] RESULT_BITS_OUT,
   input wire logic              RESULT_VALID,
   input wire logic              RESULT_READY
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   // ----------------------------------------------------------------
   // frame and result handshake checks
   // ----------------------------------------------------------------
   AST_START: assert property (!BUSY && !CONVERT_REQUEST_N |=>
      BUSY && DATA_OE && !DATA_OUT)
      else $error("request not started");
   AST_LEN: assert property ($rose(BUSY) |-> BUSY[*8] ##1 BUSY[*6])
      else $error("frame too short");
   AST_STROBES: assert property ($rose(BUSY) |->
      (!BIT_STROBE)[*4] ##1 BIT_STROBE[*8] ##1 BIT_STROBE[*2] ##1 !BIT_STROBE)
      else $error("bit strobes misplaced");
   AST_HOLD: assert property ($rose(BUSY) |-> ##2 HOLD_STROBE ##1 !HOLD_STROBE)
      else $error("hold not at cycle three");
   AST_TRACK: assert property ($rose(BUSY) |->
      TRACK[*3] ##1 (!TRACK)[*8] ##1 (!TRACK)[*2] ##1 TRACK)
      else $error("track window misplaced");
   AST_LOW_LEAD: assert property ($rose(BUSY) |-> (!DATA_OUT)[*4])
      else $error("output not low before msb");
   AST_FELL_OE: assert property ($fell(DATA_OE) |-> $past(BIT_STROBE) && !BUSY)
      else $error("driver off before lsb");
   AST_OE_BUSY: assert property (BUSY |-> DATA_OE)
      else $error("output floats in frame");
   AST_VALID_HOLD: assert property (RESULT_VALID && !RESULT_READY |=>
      RESULT_VALID && $stable(RESULT_BITS_OUT))
      else $error("result lost under stall");
   COV_SINGLE: cover property ($fell(DATA_OE));
   COV_FREE: cover property (BUSY[*8] ##1 BUSY[*8]);
   COV_STALL: cover property (RESULT_VALID && !RESULT_READY);
endmodule : sacs_seq_properties
bind sacs_sequencer sacs_seq_properties #(.N_BITS(N_BITS)) PROPS (.CLOCK(CLOCK), .RST(RST),
   .CONVERT_REQUEST_N(CONVERT_REQUEST_N), .COMPARE_BIT(COMPARE_BIT), .TRACK(TRACK),
   .HOLD_STROBE(HOLD_STROBE), .BIT_STROBE(BIT_STROBE), .DATA_OUT(DATA_OUT),
   .DATA_OE(DATA_OE), .BUSY(BUSY), .RESULT_BITS_OUT(RESULT_BITS_OUT),
   .RESULT_VALID(RESULT_VALID), .RESULT_READY(RESULT_READY));
`default_nettype wire

/* File: tb/tb.sv */
// testbench: single shot, chained and free-run frames with a stalled consumer
// assumes a 100 ns clock and inputs driven at falling edges
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sacs_pkg::*;
   logic            clk = 1'b0, rst = 1'b1, req_low = 1'b0, level = 1'b0, ready = 1'b1;
   wire logic       req_n, cmp, trk, hold, bstb, dout, doe, busy, rvalid;
   wire logic [9:0] rbits, word;
   logic [9:0]      got[$];
   int              fail_count = 0;
   int              samples_checked = 0;
   initial begin
      forever #50 clk = ~clk;
   end
   sacs_host_model HOST (.CLOCK(clk), .REQ_LOW(req_low), .LEVEL(level), .DATA_IN(dout),
      .DATA_EN(doe), .STROBE(bstb), .REQ_N(req_n), .CMP(cmp), .WORD(word));
   sacs_sequencer DUT (.CLOCK(clk), .RST(rst), .CONVERT_REQUEST_N(req_n), .COMPARE_BIT(cmp),
      .TRACK(trk), .HOLD_STROBE(hold), .BIT_STROBE(bstb), .DATA_OUT(dout), .DATA_OE(doe),
      .BUSY(busy), .RESULT_BITS_OUT(rbits), .RESULT_VALID(rvalid), .RESULT_READY(ready));
   // collect every accepted result word
   always @(posedge clk) begin
      if (!rst && rvalid && ready) got.push_back(rbits);
   end
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   task automatic t_single(input logic [9:0] exp);
      got.delete();
      level = 1'b0;
      req_low = 1'b1;
      @(negedge clk);
      req_low = 1'b0;
      repeat (3) @(negedge clk);
      // one comparator decision per bit cycle, msb first
      for (int i = 9; i >= 0; i--) begin
         level = exp[i];
         @(negedge clk);
      end
      repeat (5) @(negedge clk);
      check(word, exp);
      check(got[0], exp);
      check(10'(got.size()), 10'h001);
      check(10'(doe), 10'h000);
   endtask : t_single
   task automatic t_sync();
      got.delete();
      level = 1'b1;
      req_low = 1'b1;
      @(negedge clk);
      req_low = 1'b0;
      repeat (12) @(negedge clk);
      req_low = 1'b1;
      repeat (2) @(negedge clk);
      req_low = 1'b0;
      // driven low through the lead-in of the chained frame, then bits
      for (int i = 0; i < 12; i++) begin
         check(10'({doe, dout}), (i < 4) ? 10'h002 : 10'h003);
         @(negedge clk);
      end
      repeat (10) @(negedge clk);
      check(10'(got.size()), 10'h002);
      check(got[1], 10'h3FF);
   endtask : t_sync
   task automatic t_free();
      got.delete();
      level = 1'b1;
      ready = 1'b0;
      req_low = 1'b1;
      repeat (3) @(negedge clk);
      repeat (40) begin
         check(10'(doe), 10'h001);
         @(negedge clk);
      end
      req_low = 1'b0;
      repeat (20) @(negedge clk);
      check(10'(rvalid), 10'h001);
      ready = 1'b1;
      repeat (4) @(negedge clk);
      check(10'(got.size()), 10'h002);
      check(got[1], 10'h3FF);
   endtask : t_free
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      check(10'({doe, busy, rvalid, dout, trk}), 10'h001);
      t_single(10'h2C5);
      t_single(10'h13A);
      t_sync();
      t_free();
      close_out();
   end
   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      close_out();
   end
endmodule : tb
`default_nettype wire
